// ===== design/irrd_decoder.sv
// pulse-distance infrared remote decoder, short and long leader
`timescale 1ns/100ps
module irrd_decoder (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       ir_rx_n,
    input  wire logic       rclk_200k,
    input  wire logic       ir_enable,
    input  wire logic       serial_irq,
    input  wire logic       clr_frame,
    input  wire logic       clr_repeat,
    input  wire logic       clr_error,
    output logic            irq,
    output logic            frame_pend,
    output logic            repeat_pend,
    output logic            error_pend,
    output logic            proto_long,
    output logic [7:0]      cust_code,
    output logic [7:0]      cmd_code
);
    logic                   mark_start;
    logic                   mark_end;
    logic                   rtick;
    logic [11:0]            seg_count;
    logic [11:0]            seg_width;

    irrd_pkg::irrd_state_t  state_reg, state_next;
    logic [31:0]            bits_reg, bits_next;
    logic [5:0]             bitcnt_reg, bitcnt_next;
    logic                   long_reg, long_next;
    logic                   frame_reg, frame_next;
    logic                   repeat_reg, repeat_next;
    logic                   error_reg, error_next;
    logic [7:0]             cust_reg, cust_next;
    logic [7:0]             cmd_reg, cmd_next;

    logic                   tmo;
    logic                   done_ok;
    logic                   rep_hit;
    logic                   err_hit;
    logic                   shift_en;
    logic                   shift_bit;

    // nominal width of n units in ticks
    function automatic logic [16:0] tm_ticks(input logic [4:0] n);
        tm_ticks = 17'(n) * 17'(irrd_pkg::TM_TICKS);
    endfunction : tm_ticks

    // width within the tolerance window of n units
    function automatic logic near_tm(input logic [11:0] w, input logic [4:0] n);
        logic [16:0] nom;
        logic [16:0] tol;
        logic [16:0] wx;
        nom = tm_ticks(n);
        wx  = {5'h00, w};
        if (n > irrd_pkg::TM_BIG)
            tol = nom >> irrd_pkg::TOL_SH_BIG;
        else
            tol = 17'(irrd_pkg::TM_TICKS >> irrd_pkg::TOL_SH_SML);
        near_tm = (wx + tol >= nom) && (wx <= nom + tol);
    endfunction : near_tm

    // copy checks on a complete 32-bit frame
    function automatic logic frame_ok(input logic [31:0] b, input logic lng);
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] k1;
        logic [7:0] k2;
        c1 = b[irrd_pkg::CUST_LSB +: 8];
        c2 = b[irrd_pkg::CUST2_LSB +: 8];
        k1 = b[irrd_pkg::CMD_LSB +: 8];
        k2 = b[irrd_pkg::CMD2_LSB +: 8];
        if (lng)
            frame_ok = (c2 == ~c1) && (k2 == ~k1);
        else
            frame_ok = (c2 == c1) && (k2 == ~k1);
    endfunction : frame_ok

    irrd_sync u_sync (
        .mclk       (mclk),
        .rstn       (rstn),
        .ir_rx_n    (ir_rx_n),
        .rclk_200k  (rclk_200k),
        .mark_start (mark_start),
        .mark_end   (mark_end),
        .rtick      (rtick)
    );

    irrd_timer u_timer (
        .mclk       (mclk),
        .rstn       (rstn),
        .rtick      (rtick),
        .seg_edge   (mark_start | mark_end),
        .seg_count  (seg_count),
        .seg_width  (seg_width)
    );

    // silence limit depends on whether the leader is being measured
    always_comb begin
        if (state_reg == irrd_pkg::ST_LEAD_MARK || state_reg == irrd_pkg::ST_LEAD_SPACE)
            tmo = {5'h00, seg_count} >= tm_ticks(irrd_pkg::TMO_LEAD);
        else
            tmo = {5'h00, seg_count} >= tm_ticks(irrd_pkg::TMO_BIT);
    end

    // frame sequencer
    always_comb begin
        state_next  = state_reg;
        bits_next   = bits_reg;
        bitcnt_next = bitcnt_reg;
        long_next   = long_reg;
        done_ok     = 1'b0;
        rep_hit     = 1'b0;
        err_hit     = 1'b0;
        shift_en    = 1'b0;
        shift_bit   = 1'b0;
        case (state_reg)
            irrd_pkg::ST_IDLE: begin
                if (mark_start) begin
                    state_next = irrd_pkg::ST_LEAD_MARK;
                end
            end
            irrd_pkg::ST_LEAD_MARK: begin
                if (mark_end) begin
                    if (near_tm(seg_width, irrd_pkg::TM_16)) begin
                        long_next  = 1'b1;
                        state_next = irrd_pkg::ST_LEAD_SPACE;
                    end else if (near_tm(seg_width, irrd_pkg::TM_8)) begin
                        long_next  = 1'b0;
                        state_next = irrd_pkg::ST_LEAD_SPACE;
                    end else begin
                        err_hit = 1'b1;
                    end
                end else if (tmo) begin
                    err_hit = 1'b1;
                end
            end
            irrd_pkg::ST_LEAD_SPACE: begin
                if (mark_start) begin
                    if (near_tm(seg_width, irrd_pkg::TM_8)) begin
                        bitcnt_next = '0;
                        state_next  = irrd_pkg::ST_DATA_MARK;
                    end else if (long_reg && near_tm(seg_width, irrd_pkg::TM_4)) begin
                        state_next = irrd_pkg::ST_REP_MARK;
                    end else begin
                        err_hit = 1'b1;
                    end
                end else if (tmo) begin
                    err_hit = 1'b1;
                end
            end
            irrd_pkg::ST_DATA_MARK: begin
                if (mark_end) begin
                    if (near_tm(seg_width, irrd_pkg::TM_1))
                        state_next = irrd_pkg::ST_DATA_SPACE;
                    else
                        err_hit = 1'b1;
                end else if (tmo) begin
                    err_hit = 1'b1;
                end
            end
            irrd_pkg::ST_DATA_SPACE: begin
                // burst plus space: 2 units is zero, 4 units is one
                if (mark_start) begin
                    if (bitcnt_reg == irrd_pkg::FRAME_BITS) begin
                        err_hit = 1'b1;
                    end else if (near_tm(seg_width, irrd_pkg::TM_1)) begin
                        shift_en  = 1'b1;
                        shift_bit = 1'b0;
                    end else if (near_tm(seg_width, irrd_pkg::TM_3)) begin
                        shift_en  = 1'b1;
                        shift_bit = 1'b1;
                    end else begin
                        err_hit = 1'b1;
                    end
                end else if (tmo) begin
                    if (bitcnt_reg == irrd_pkg::FRAME_BITS) begin
                        if (frame_ok(bits_reg, long_reg))
                            done_ok = 1'b1;
                        else
                            err_hit = 1'b1;
                    end else if (bitcnt_reg == '0 && !long_reg) begin
                        rep_hit = 1'b1;
                    end else begin
                        err_hit = 1'b1;
                    end
                end
            end
            irrd_pkg::ST_REP_MARK: begin
                if (mark_end) begin
                    if (near_tm(seg_width, irrd_pkg::TM_1))
                        state_next = irrd_pkg::ST_REP_SPACE;
                    else
                        err_hit = 1'b1;
                end else if (tmo) begin
                    err_hit = 1'b1;
                end
            end
            irrd_pkg::ST_REP_SPACE: begin
                if (mark_start)
                    err_hit = 1'b1;
                else if (tmo)
                    rep_hit = 1'b1;
            end
            default: begin
                state_next = irrd_pkg::ST_IDLE;
            end
        endcase
        if (shift_en) begin
            bits_next   = {shift_bit, bits_reg[31:1]};
            bitcnt_next = bitcnt_reg + 6'h01;
            state_next  = irrd_pkg::ST_DATA_MARK;
        end
        if (err_hit || rep_hit || done_ok)
            state_next = irrd_pkg::ST_IDLE;
        if (!ir_enable)
            state_next = irrd_pkg::ST_IDLE;
    end

    // pending flags and decoded codes; a set beats a clear in the same cycle
    always_comb begin
        frame_next  = (frame_reg & ~clr_frame) | done_ok;
        repeat_next = (repeat_reg & ~clr_repeat) | rep_hit;
        error_next  = (error_reg & ~clr_error) | err_hit;
        cust_next   = cust_reg;
        cmd_next    = cmd_reg;
        if (done_ok) begin
            cust_next = bits_reg[irrd_pkg::CUST_LSB +: 8];
            cmd_next  = bits_reg[irrd_pkg::CMD_LSB +: 8];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_reg  <= irrd_pkg::ST_IDLE;
            bits_reg   <= '0;
            bitcnt_reg <= '0;
            long_reg   <= 1'b0;
            frame_reg  <= 1'b0;
            repeat_reg <= 1'b0;
            error_reg  <= 1'b0;
            cust_reg   <= '0;
            cmd_reg    <= '0;
        end else begin
            state_reg  <= state_next;
            bits_reg   <= bits_next;
            bitcnt_reg <= bitcnt_next;
            long_reg   <= long_next;
            frame_reg  <= frame_next;
            repeat_reg <= repeat_next;
            error_reg  <= error_next;
            cust_reg   <= cust_next;
            cmd_reg    <= cmd_next;
        end
    end

    // shared line with the first serial port
    assign irq         = serial_irq | frame_reg | repeat_reg | error_reg;
    assign frame_pend  = frame_reg;
    assign repeat_pend = repeat_reg;
    assign error_pend  = error_reg;
    assign proto_long  = long_reg;
    assign cust_code   = cust_reg;
    assign cmd_code    = cmd_reg;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_short_lead;
        state_reg == irrd_pkg::ST_LEAD_MARK && mark_end && near_tm(seg_width, irrd_pkg::TM_8);
    endsequence
    sequence s_long_lead;
        state_reg == irrd_pkg::ST_LEAD_MARK && mark_end && near_tm(seg_width, irrd_pkg::TM_16);
    endsequence
    sequence s_one_bit;
        state_reg == irrd_pkg::ST_DATA_SPACE && mark_start && ir_enable &&
        bitcnt_reg < irrd_pkg::FRAME_BITS && near_tm(seg_width, irrd_pkg::TM_3);
    endsequence

    property p_irq_share;
        serial_irq |-> irq;
    endproperty
    a_irq_share: assert property (p_irq_share) else $error("serial irq not on shared line");

    property p_lead_short;
        s_short_lead |=> !long_reg && state_reg inside {irrd_pkg::ST_LEAD_SPACE, irrd_pkg::ST_IDLE};
    endproperty
    a_lead_short: assert property (p_lead_short) else $error("short leader not taken");

    property p_lead_long;
        s_long_lead |=> long_reg;
    endproperty
    a_lead_long: assert property (p_lead_long) else $error("long leader not taken");

    property p_bit_one;
        s_one_bit |=> bits_reg[31] && bitcnt_reg == $past(bitcnt_reg) + 6'h01;
    endproperty
    a_bit_one: assert property (p_bit_one) else $error("four-unit period not decoded as one");

    property p_lsb_first;
        shift_en && ir_enable |=> bits_reg[30:0] == $past(bits_reg[31:1]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("bits not shifted lsb first");

    property p_long_copy;
        done_ok && long_reg |-> bits_reg[15:8] == ~bits_reg[7:0] ##1 frame_reg && cust_reg == $past(bits_reg[7:0]);
    endproperty
    a_long_copy: assert property (p_long_copy) else $error("long frame copy check wrong");

    property p_short_cmd;
        done_ok && !long_reg |-> bits_reg[31:24] == ~bits_reg[23:16] ##1 cmd_reg == $past(bits_reg[23:16]);
    endproperty
    a_short_cmd: assert property (p_short_cmd) else $error("short frame command check wrong");

    property p_rep_long;
        state_reg == irrd_pkg::ST_REP_SPACE && tmo && !mark_start |=> repeat_reg && state_reg == irrd_pkg::ST_IDLE;
    endproperty
    a_rep_long: assert property (p_rep_long) else $error("long repeat not flagged");

    property p_rep_short;
        state_reg == irrd_pkg::ST_DATA_SPACE && bitcnt_reg == '0 && !long_reg && tmo && !mark_start |=> repeat_reg;
    endproperty
    a_rep_short: assert property (p_rep_short) else $error("short repeat not flagged");

    property p_set_wins;
        rep_hit && clr_repeat |=> repeat_reg;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("repeat lost to clear");

    property p_bad_mark;
        state_reg == irrd_pkg::ST_DATA_MARK && mark_end && !near_tm(seg_width, irrd_pkg::TM_1)
        |=> error_reg && state_reg == irrd_pkg::ST_IDLE;
    endproperty
    a_bad_mark: assert property (p_bad_mark) else $error("bad burst width not flagged");

    property p_idle_start;
        state_reg == irrd_pkg::ST_IDLE && ir_enable && mark_start |=> state_reg == irrd_pkg::ST_LEAD_MARK;
    endproperty
    a_idle_start: assert property (p_idle_start) else $error("low pin not seen as burst");

endmodule : irrd_decoder

// ===== include/irrd_pkg.sv
// constants and types for the infrared remote decoder
package irrd_pkg;

    // time base: base_time_unit = 256 periods of 455kHz, timed in 200kHz ticks
    localparam int          RCLK_HZ     = 200000;
    localparam int          FOSC_HZ     = 455000;
    localparam int          TM_DIV      = 256;
    localparam int          TM_TICKS_I  = RCLK_HZ * TM_DIV / FOSC_HZ;
    localparam int          CW          = 12;
    localparam logic [11:0] TM_TICKS    = 12'(TM_TICKS_I);
    localparam logic [11:0] CNT_MAX     = 12'hfff;

    // nominal widths in base_time_unit multiples
    localparam logic [4:0]  TM_1        = 5'h01;
    localparam logic [4:0]  TM_3        = 5'h03;
    localparam logic [4:0]  TM_4        = 5'h04;
    localparam logic [4:0]  TM_8        = 5'h08;
    localparam logic [4:0]  TM_16       = 5'h10;

    // tolerance: half a unit up to TM_BIG, a quarter of nominal above it
    localparam logic [4:0]  TM_BIG      = 5'h04;
    localparam int          TOL_SH_SML  = 1;
    localparam int          TOL_SH_BIG  = 2;

    // silence limits ending a segment
    localparam logic [4:0]  TMO_BIT     = 5'h06;
    localparam logic [4:0]  TMO_LEAD    = 5'h14;

    // frame layout, lsb first
    localparam logic [5:0]  FRAME_BITS  = 6'h20;
    localparam int          CUST_LSB    = 0;
    localparam int          CUST2_LSB   = 8;
    localparam int          CMD_LSB     = 16;
    localparam int          CMD2_LSB    = 24;

    // reset levels of the synchronisers
    localparam logic        IR_IDLE     = 1'b1;
    localparam logic        RCLK_RST    = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD_MARK,
        ST_LEAD_SPACE,
        ST_DATA_MARK,
        ST_DATA_SPACE,
        ST_REP_MARK,
        ST_REP_SPACE
    } irrd_state_t;

endpackage : irrd_pkg

// ===== design/irrd_sync.sv
// pin synchronisers, edge and tick detection
`timescale 1ns/100ps
module irrd_sync (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic ir_rx_n,
    input  wire logic rclk_200k,
    output logic      mark_start,
    output logic      mark_end,
    output logic      rtick
);
    logic ir_s1_reg, ir_s2_reg, ir_s3_reg;
    logic rc_s1_reg, rc_s2_reg, rc_s3_reg;
    logic ir_s1_next, ir_s2_next, ir_s3_next;
    logic rc_s1_next, rc_s2_next, rc_s3_next;

    always_comb begin
        ir_s1_next = ir_rx_n;
        ir_s2_next = ir_s1_reg;
        ir_s3_next = ir_s2_reg;
        rc_s1_next = rclk_200k;
        rc_s2_next = rc_s1_reg;
        rc_s3_next = rc_s2_reg;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ir_s1_reg <= irrd_pkg::IR_IDLE;
            ir_s2_reg <= irrd_pkg::IR_IDLE;
            ir_s3_reg <= irrd_pkg::IR_IDLE;
            rc_s1_reg <= irrd_pkg::RCLK_RST;
            rc_s2_reg <= irrd_pkg::RCLK_RST;
            rc_s3_reg <= irrd_pkg::RCLK_RST;
        end else begin
            ir_s1_reg <= ir_s1_next;
            ir_s2_reg <= ir_s2_next;
            ir_s3_reg <= ir_s3_next;
            rc_s1_reg <= rc_s1_next;
            rc_s2_reg <= rc_s2_next;
            rc_s3_reg <= rc_s3_next;
        end
    end

    // burst shows as low level on the receiver pin
    assign mark_start = ir_s3_reg & ~ir_s2_reg;
    assign mark_end   = ~ir_s3_reg & ir_s2_reg;
    // one tick per rising edge of the 200kHz clock
    assign rtick      = rc_s2_reg & ~rc_s3_reg;

endmodule : irrd_sync

// ===== design/irrd_timer.sv
// segment width counter in 200kHz ticks
`timescale 1ns/100ps
module irrd_timer (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        rtick,
    input  wire logic        seg_edge,
    output logic [11:0]      seg_count,
    output logic [11:0]      seg_width
);
    logic [11:0] cnt_reg, cnt_next;
    logic [11:0] width_reg, width_next;

    always_comb begin
        cnt_next   = cnt_reg;
        width_next = width_reg;
        if (seg_edge) begin
            cnt_next   = '0;
            width_next = cnt_reg;
        end else if (rtick && cnt_reg != irrd_pkg::CNT_MAX) begin
            cnt_next = cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_reg   <= '0;
            width_reg <= '0;
        end else begin
            cnt_reg   <= cnt_next;
            width_reg <= width_next;
        end
    end

    assign seg_count = cnt_reg;
    assign seg_width = width_next;

endmodule : irrd_timer

// ===== bench/irrd_remote_model.sv
// remote transmitter seen through the receiver module, demodulated
`timescale 1ns/100ps
module irrd_remote_model (
    input  wire logic mclk,
    input  wire logic rclk_200k,
    output logic      ir_rx_n
);
    // receiver output idles high; a burst shows as low
    initial ir_rx_n = 1'b1;

    // carrier already removed by the receiver module
    // one level for a number of base_time_units counted in ticks
    task automatic seg(input logic lvl, input int units);
        @(negedge mclk);
        ir_rx_n = lvl;
        repeat (units * int'(irrd_pkg::TM_TICKS)) @(posedge rclk_200k);
    endtask : seg

    // leader, 32 bits lsb first, stop burst, then release
    task automatic send_frame(input logic lng, input logic [31:0] bits);
        seg(1'b0, lng ? 16 : 8);
        seg(1'b1, 8);
        for (int i = 0; i < 32; i++) begin
            seg(1'b0, 1);
            seg(1'b1, bits[i] ? 3 : 1);
        end
        seg(1'b0, 1);
        seg(1'b1, 0);
    endtask : send_frame

    // repeat code of either protocol
    task automatic send_repeat(input logic lng);
        seg(1'b0, lng ? 16 : 8);
        seg(1'b1, lng ? 4 : 8);
        seg(1'b0, 1);
        seg(1'b1, 0);
    endtask : send_repeat
endmodule : irrd_remote_model

// ===== bench/tb_irrd_decoder.sv
// self-checking bench for the infrared remote decoder
`timescale 1ns/100ps
module tb_irrd_decoder;
    // time base runs at 2 mclk per tick, the fastest the synchroniser can follow
    localparam int RDIV     = 2;
    localparam int UNIT_CYC = int'(irrd_pkg::TM_TICKS) * RDIV;

    logic       mclk, rstn, rclk_200k, ir_rx_n, ir_enable, serial_irq;
    logic       clr_frame, clr_repeat, clr_error;
    logic       irq, frame_pend, repeat_pend, error_pend, proto_long;
    logic [7:0] cust_code, cmd_code;
    int         error_cnt, checked;

    irrd_decoder i_dut (
        .mclk(mclk), .rstn(rstn), .ir_rx_n(ir_rx_n), .rclk_200k(rclk_200k),
        .ir_enable(ir_enable), .serial_irq(serial_irq), .clr_frame(clr_frame),
        .clr_repeat(clr_repeat), .clr_error(clr_error), .irq(irq), .frame_pend(frame_pend),
        .repeat_pend(repeat_pend), .error_pend(error_pend), .proto_long(proto_long),
        .cust_code(cust_code), .cmd_code(cmd_code)
    );

    irrd_remote_model i_remote (.mclk(mclk), .rclk_200k(rclk_200k), .ir_rx_n(ir_rx_n));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        rclk_200k = 1'b0;
        #7;
        forever #(RDIV * 20) rclk_200k = ~rclk_200k;
    end

    task test_done();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    // bounded wait for any pending flag
    task automatic wait_event(input int units);
        int n;
        n = 0;
        while ((frame_pend | repeat_pend | error_pend) !== 1'b1 && n < units * UNIT_CYC) begin
            @(negedge mclk);
            n++;
        end
        if (n >= units * UNIT_CYC) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: no event", $time);
            test_done();
        end
    endtask : wait_event

    task clr_all();
        @(negedge mclk);
        {clr_frame, clr_repeat, clr_error} = 3'h7;
        @(negedge mclk);
        {clr_frame, clr_repeat, clr_error} = 3'h0;
        chk({frame_pend, repeat_pend, error_pend, irq} === 4'h0, "flags not cleared");
    endtask : clr_all

    task frame_case(input logic lng, input logic [31:0] bits, input logic ok, input logic [7:0] c,
                    input logic [7:0] m);
        i_remote.send_frame(lng, bits);
        wait_event(12);
        @(negedge mclk);
        chk({frame_pend, error_pend, repeat_pend} === {ok, !ok, 1'b0}, "frame verdict");
        chk({cust_code, cmd_code} === {c, m}, "codes");
        chk(irq === 1'b1, "irq");
        if (ok) chk(proto_long === lng, "protocol");
        clr_all();
    endtask : frame_case

    // hold_clr keeps the repeat clear high so the set meets a clear
    task repeat_case(input logic lng, input logic [7:0] c, input logic [7:0] m, input logic hold_clr);
        @(negedge mclk);
        clr_repeat = hold_clr;
        i_remote.send_repeat(lng);
        wait_event(12);
        clr_repeat = 1'b0;
        @(negedge mclk);
        chk({frame_pend, error_pend, repeat_pend} === 3'h1, "repeat verdict");
        chk({cust_code, cmd_code} === {c, m}, "codes kept");
        clr_all();
    endtask : repeat_case

    task t_reset();
        chk({irq, frame_pend, repeat_pend, error_pend, proto_long} === 5'h0, "reset flags");
        chk({cust_code, cmd_code} === 16'h0, "reset codes");
        serial_irq = 1'b1;
        @(negedge mclk);
        chk(irq === 1'b1, "serial irq shared");
        serial_irq = 1'b0;
    endtask : t_reset

    task t_disabled();
        ir_enable = 1'b0;
        i_remote.send_repeat(1'b0);
        repeat (8 * UNIT_CYC) @(negedge mclk);
        chk({frame_pend, repeat_pend, error_pend} === 3'h0, "decoded while disabled");
        ir_enable = 1'b1;
    endtask : t_disabled

    // full frame then one repeat while the key stays down
    task t_short_press();
        frame_case(1'b0, {~8'h34, 8'h34, 8'h12, 8'h12}, 1'b1, 8'h12, 8'h34);
        i_remote.seg(1'b1, 4);
        repeat_case(1'b0, 8'h12, 8'h34, 1'b0);
    endtask : t_short_press

    task t_long_press();
        frame_case(1'b1, {~8'h06, 8'h06, ~8'h81, 8'h81}, 1'b1, 8'h81, 8'h06);
        repeat_case(1'b1, 8'h81, 8'h06, 1'b1);
    endtask : t_long_press

    task t_bad_copies();
        frame_case(1'b0, {8'h00, 8'h00, 8'h00, 8'h00}, 1'b0, 8'h81, 8'h06);
        frame_case(1'b1, {8'hff, 8'h00, 8'h00, 8'h00}, 1'b0, 8'h81, 8'h06);
    endtask : t_bad_copies

    task t_bad_width();
        i_remote.seg(1'b0, 5);
        i_remote.seg(1'b1, 0);
        wait_event(25);
        @(negedge mclk);
        chk({frame_pend, repeat_pend, error_pend} === 3'h1, "bad leader width");
        clr_all();
        i_remote.seg(1'b0, 8);
        i_remote.seg(1'b1, 8);
        i_remote.seg(1'b0, 3);
        i_remote.seg(1'b1, 0);
        wait_event(4);
        @(negedge mclk);
        chk({frame_pend, repeat_pend, error_pend} === 3'h1, "bad data burst width");
        clr_all();
    endtask : t_bad_width

    initial begin
        error_cnt = 0;
        checked = 0;
        rstn = 1'b0;
        ir_enable = 1'b1;
        serial_irq = 1'b0;
        {clr_frame, clr_repeat, clr_error} = 3'h0;
        repeat (16) @(negedge mclk);
        rstn = 1'b1;
        @(negedge mclk);
        t_reset();
        t_disabled();
        t_short_press();
        t_long_press();
        t_bad_copies();
        t_bad_width();
        test_done();
    end
endmodule : tb_irrd_decoder
